// [logic/sbl_pkg.sv]
// Constants and state encoding for the serial boot command loader
package sbl_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_HZ       = 100_000_000;
	localparam int BAUD_MIN_BPS = 9600;
	localparam int BAUD_MAX_BPS = 128_000;
	localparam int SIO_MAX_BPS  = 250_000;
	// Shortest bit rounds up, longest rounds down
	localparam int BIT_MIN_CYC  = (CLK_HZ + BAUD_MAX_BPS - 1) / BAUD_MAX_BPS;
	localparam int BIT_MAX_CYC  = CLK_HZ / BAUD_MIN_BPS;
	localparam int PER_W        = 16;
	localparam int CNT_W        = 17;
	// Start bit and data bit 0 of 0x86 form one low pulse of two bits
	localparam int AB_LOW_BITS  = 2;
	localparam int AB_TAIL_BITS = 8;
	localparam logic [3:0] UART_STOP_IDX = 4'h8;
	localparam logic [3:0] UART_LAST_IDX = 4'h9;

	// ==========================================================
	// Link selection and command codes
	localparam logic [7:0] SEL_UART   = 8'h86;
	localparam logic [7:0] SEL_SIO    = 8'h30;
	localparam logic [7:0] MATCH2_A   = 8'h79;
	localparam logic [7:0] MATCH2_B   = 8'hCF;
	localparam logic [7:0] CMD_ERASE  = 8'hF0;
	localparam logic [7:0] CMD_WRITE  = 8'h30;
	localparam logic [7:0] CMD_READ   = 8'h40;
	localparam logic [7:0] CMD_RAMLD  = 8'h60;
	localparam logic [7:0] CMD_SUM    = 8'h90;
	localparam logic [7:0] CMD_ID     = 8'hC0;
	localparam logic [7:0] CMD_STAT   = 8'hC3;
	localparam logic [7:0] CMD_MROM   = 8'hD0;
	localparam logic [7:0] CMD_SECURE = 8'hFA;
	localparam logic [7:0] ERR_CMD    = 8'hA1;
	localparam logic [7:0] ERR_SEC    = 8'hA3;
	localparam logic [7:0] ERR_PWD    = 8'h63;
	localparam logic [7:0] CHECK_BYTE = 8'hFF;
	localparam logic [7:0] OPT_OPEN   = 8'hFF;
	localparam logic [7:0] AREA_CHIP  = 8'h00;
	localparam logic [1:0] ERR_REPEAT = 2'h3;

	// ==========================================================
	// Address ranges
	localparam logic [15:0] FLASH_LO    = 16'h8000;
	localparam logic [15:0] FLASH_HI    = 16'hFFFF;
	localparam logic [15:0] RAM_LO      = 16'h0060;
	localparam logic [15:0] RAM_HI      = 16'h083F;
	localparam int          SECTOR_BITS = 12;

	typedef enum logic [3:0] {
		ST_STANDBY, ST_AB_LOW, ST_AB_TAIL, ST_MATCH2, ST_CMD,
		ST_AREA, ST_EXEC, ST_SEND, ST_HALT
	} sbl_st_e;
endpackage

// [logic/sbl_loader.sv]
// Serial boot command loader: link selection, autobaud and command decode
// Functional notes
// (R1) Controller holds reset, pins high, then sends byte
// (R2) First byte 0x86 picks UART, 0x30 sync
// (R3) Sync link: slave, 8-bit words, max 250 kbps
// (R4) Sync out low while busy, high when ready
// (R5) Controller waits for ready before clocking
// (R6) UART frames: 8 bits LSB first, one stop
// (R7) Baud measured from 0x86, used thereafter
// (R8) Detected baud between 9600 and 128000
// (R9) Standby after reset until first byte
// (R10) 0xF0 erases flash 0x8000 to 0xFFFF
// (R11) 0x30 after setup writes flash
// (R12) 0x40 reads flash back
// (R13) 0x60 RAM loader, addresses 0x0060-0x083F
// (R14) 0x90 sends 0xFF then checksum high first
// (R15) 0xC0 product codes, 0xC3 status codes
// (R16) 0xFA turns security on
// (R17) Chip or 4K sector erase, reads 0xFF
// (R18) Sector erase refused if secured or 0xFF
// (R19) Chip erase clears security
// (R20) Password needed unless blank or 0xFF
// (R21) Run-mode flash addresses translated to physical
// (R22) RAM program switches flash areas itself
// (R23) Second byte 0x79/0xCF echoed, else silence
// (R24) Bad command: error code thrice, then idle
// (R25) UART bits sampled at mid period
`timescale 1ns/1ps

// ==========================================================
// Sync serial link, clocked by the controller's serial clock
module sbl_sio_link (
	input  wire logic       sclk,
	input  wire logic       rst,
	input  wire logic       si,
	output logic [7:0]      rx_byte,
	output logic [2:0]      idx_gray,
	output logic            byte_tgl
);
	typedef struct packed {
		logic [7:0] sh;
		logic [7:0] byte_q;
		logic [2:0] cnt;
		logic [2:0] gray;
		logic       tgl;
	} sbl_link_s;

	sbl_link_s r, n;

	always_comb begin
		n = r;
		n.sh = {si, r.sh[7:1]}; // (R3)
		n.cnt = r.cnt + 3'h1;
		n.gray = n.cnt ^ (n.cnt >> 1);
		if (r.cnt == 3'h7) begin
			n.byte_q = {si, r.sh[7:1]};
			n.tgl = ~r.tgl;
		end
	end

	// The serial clock stands still at reset, so reset acts without it
	always_ff @(posedge sclk or posedge rst) begin
		if (rst)
			r <= '0;
		else
			r <= n;
	end

	assign rx_byte  = r.byte_q;
	assign idx_gray = r.gray;
	assign byte_tgl = r.tgl;
endmodule // sbl_sio_link

// ==========================================================
// Top: command interpreter on the system clock
module sbl_loader #(
	parameter int BIT_MAX_CYC = sbl_pkg::BIT_MAX_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sync_serial_clock_pin,
	input  wire logic        sync_serial_in_pin,
	output logic             sync_serial_out_pin,
	input  wire logic        uart_rx_pin,
	output logic             uart_tx_pin,
	input  wire logic [7:0]  erase_protect_option_code,
	input  wire logic        part_blank,
	input  wire logic        password_ok,
	input  wire logic        security_strap,
	input  wire logic        cmd_done,
	input  wire logic        cmd_fail,
	input  wire logic [15:0] checksum,
	input  wire logic        eng_tx_valid,
	input  wire logic [7:0]  eng_tx_data,
	output logic             eng_tx_ready,
	input  wire logic [15:0] loader_addr,
	input  wire logic        loader_addr_valid,
	output logic             ram_addr_bad,
	output logic             cmd_start,
	output logic [7:0]       cmd_code,
	output logic             erase_chip,
	output logic             erase_sector,
	output logic [14:0]      erase_base,
	output logic             fwd_valid,
	output logic [7:0]       fwd_data,
	output logic             security_enable,
	output logic             sio_mode
);
	localparam int PW = sbl_pkg::PER_W;
	localparam int CW = sbl_pkg::CNT_W;
	localparam logic [CW-1:0] AB_LIM =
		CW'(sbl_pkg::AB_LOW_BITS * BIT_MAX_CYC);

	typedef struct packed {
		sbl_pkg::sbl_st_e st;
		sbl_pkg::sbl_st_e nxt;
		logic             sio;
		logic [2:0]       rxs;
		logic [2:0]       g1, g2;
		logic [2:0]       t;
		logic [PW-1:0]    per;
		logic [CW-1:0]    cnt;
		logic [3:0]       bitn;
		logic             ub;
		logic [PW-1:0]    uc;
		logic [3:0]       un;
		logic [7:0]       us;
		logic             tb;
		logic [PW-1:0]    tc;
		logic [3:0]       tn;
		logic [8:0]       ts;
		logic             line;
		logic             tp;
		logic [7:0]       tbyte;
		logic             so;
		logic             rdy;
		logic [2:0][7:0]  q;
		logic [1:0]       qn;
		logic             stream;
		logic             sec;
		logic             strap;
		logic [7:0]       cmd;
		logic             start;
		logic             chip;
		logic             sect;
		logic [14:0]      base;
		logic             fwd_v;
		logic [7:0]       fwd_d;
		logic             etx_rdy;
		logic             ram_bad;
	} sbl_core_s;

	sbl_core_s r, n;

	logic [7:0] link_byte;
	logic [2:0] link_gray;
	logic       link_tgl;

	sbl_sio_link u_link (
		.sclk     (sync_serial_clock_pin),
		.rst      (rst),
		.si       (sync_serial_in_pin),
		.rx_byte  (link_byte),
		.idx_gray (link_gray),
		.byte_tgl (link_tgl)
	);

	function automatic logic [2:0] gray2bin(input logic [2:0] g);
		return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
	endfunction

	function automatic logic [14:0] phys(input logic [15:0] a);
		return 15'(a - sbl_pkg::FLASH_LO); // (R21)
	endfunction

	function automatic logic in_rng(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	logic            sev, fell, setup, uart_on, tx_idle, push, sio_sel;
	logic            rxv, qload, pwd_need, refuse;
	logic [7:0]      rxb, pbyte;
	logic [2:0]      idx;
	logic [2:0][7:0] qv;
	logic [1:0]      qc;
	logic [15:0]     sec_addr;
	sbl_pkg::sbl_st_e qnext;

	always_comb begin
		n = r;
		rxv = 1'b0;
		rxb = 8'h00;
		push = 1'b0;
		pbyte = 8'h00;
		qload = 1'b0;
		qv = '0;
		qc = 2'h0;
		qnext = sbl_pkg::ST_CMD;
		sec_addr = 16'h0000;
		pwd_need = 1'b0;
		refuse = 1'b0;
		n.start = 1'b0;
		n.fwd_v = 1'b0;
		n.etx_rdy = 1'b0;
		n.rxs = {r.rxs[1:0], uart_rx_pin};
		n.g1 = link_gray;
		n.g2 = r.g1;
		n.t = {r.t[1:0], link_tgl};
		idx = gray2bin(r.g2);
		sev = r.t[1] ^ r.t[2];
		fell = r.rxs[2] & ~r.rxs[1];
		setup = (r.st == sbl_pkg::ST_STANDBY) ||
			(r.st == sbl_pkg::ST_AB_LOW) || (r.st == sbl_pkg::ST_AB_TAIL);
		uart_on = !r.sio && !setup;
		tx_idle = r.sio ? !r.tp : !r.tb;
		// Security state is loaded once, one cycle after reset release
		n.strap = 1'b1;
		if (!r.strap)
			n.sec = security_strap;

		// Sync bytes: a byte clocked while one was pending was a read
		sio_sel = sev && setup && !r.sio && (link_byte == sbl_pkg::SEL_SIO);
		if (sev && r.tp)
			n.tp = 1'b0;
		else if (sev && r.sio) begin
			rxv = 1'b1;
			rxb = link_byte;
		end

		// UART receiver, bits taken at mid period
		if (uart_on) begin
			if (!r.ub) begin
				if (fell) begin
					n.ub = 1'b1;
					n.uc = r.per >> 1; // (R25)
					n.un = 4'h0;
				end
			end else if (r.uc != '0)
				n.uc = r.uc - 16'h0001;
			else begin
				n.uc = r.per - 16'h0001; // (R7)
				n.un = r.un + 4'h1;
				if (r.un == 4'h0 && r.rxs[1])
					n.ub = 1'b0;
				else if (r.un != 4'h0 && r.un <= sbl_pkg::UART_STOP_IDX)
					n.us = {r.rxs[1], r.us[7:1]}; // (R6)
				// Index 9 is the stop bit; r.us then holds all 8 data bits
				if (r.un == sbl_pkg::UART_LAST_IDX) begin
					n.ub = 1'b0;
					// Missing stop bit drops the byte
					rxv = r.rxs[1]; // (R6)
					rxb = r.us;
				end
			end
		end

		// UART transmitter: start, 8 data LSB first, one stop
		if (r.tb) begin
			if (r.tc != '0)
				n.tc = r.tc - 16'h0001;
			else if (r.tn == sbl_pkg::UART_LAST_IDX)
				n.tb = 1'b0;
			else begin
				n.line = r.ts[0]; // (R6)
				n.ts = {1'b1, r.ts[8:1]};
				n.tn = r.tn + 4'h1;
				n.tc = r.per - 16'h0001; // (R7)
			end
		end

		case (r.st)
		sbl_pkg::ST_STANDBY: begin
			n.cnt = '0;
			if (fell)
				n.st = sbl_pkg::ST_AB_LOW; // (R9)
		end
		sbl_pkg::ST_AB_LOW: begin
			n.cnt = r.cnt + 17'h00001;
			if (r.rxs[1]) begin
				// Low pulse spans two bits; halve it for one bit
				n.per = r.cnt[CW-1:1]; // (R7)
				n.cnt = '0;
				n.bitn = 4'h0;
				if (n.per >= PW'(sbl_pkg::BIT_MIN_CYC) &&
						n.per <= PW'(BIT_MAX_CYC)) // (R8)
					n.st = sbl_pkg::ST_AB_TAIL;
				else
					n.st = sbl_pkg::ST_STANDBY;
			end else if (r.cnt == AB_LIM)
				n.st = sbl_pkg::ST_STANDBY;
		end
		sbl_pkg::ST_AB_TAIL: begin
			// Sit out the rest of the selection frame before echoing
			n.cnt = r.cnt + 17'h00001;
			if (r.cnt == {1'b0, r.per} - 17'h00001) begin
				n.cnt = '0;
				n.bitn = r.bitn + 4'h1;
				if (r.bitn == 4'(sbl_pkg::AB_TAIL_BITS - 1)) begin
					qload = 1'b1; // (R2)
					qv[0] = sbl_pkg::SEL_UART;
					qc = 2'h1;
					qnext = sbl_pkg::ST_MATCH2;
				end
			end
		end
		sbl_pkg::ST_MATCH2: begin
			if (rxv && (rxb == sbl_pkg::MATCH2_A ||
					rxb == sbl_pkg::MATCH2_B)) begin
				qload = 1'b1; // (R23)
				qv[0] = rxb;
				qc = 2'h1;
			end
		end
		sbl_pkg::ST_CMD: begin
			if (rxv) begin
				n.cmd = rxb;
				n.stream = 1'b0;
				n.chip = 1'b0;
				n.sect = 1'b0;
				qload = 1'b1;
				qv[0] = rxb;
				qc = 2'h1;
				case (rxb)
				sbl_pkg::CMD_ERASE:
					qnext = sbl_pkg::ST_AREA; // (R10)
				sbl_pkg::CMD_WRITE, sbl_pkg::CMD_READ,
				sbl_pkg::CMD_RAMLD: begin
					n.stream = 1'b1; // (R11) (R12) (R13)
					qnext = sbl_pkg::ST_EXEC;
					if (r.sec) begin
						qv = {3{sbl_pkg::ERR_SEC}};
						qc = sbl_pkg::ERR_REPEAT;
						qnext = sbl_pkg::ST_HALT;
					end
				end
				sbl_pkg::CMD_SUM:
					qnext = sbl_pkg::ST_EXEC; // (R14)
				sbl_pkg::CMD_ID, sbl_pkg::CMD_STAT: begin
					n.stream = 1'b1; // (R15)
					qnext = sbl_pkg::ST_EXEC;
				end
				sbl_pkg::CMD_SECURE:
					n.sec = 1'b1; // (R16)
				sbl_pkg::CMD_MROM: ;
				default: begin
					qv = {3{sbl_pkg::ERR_CMD}}; // (R24)
					qc = sbl_pkg::ERR_REPEAT;
					qnext = sbl_pkg::ST_HALT;
				end
				endcase
			end
		end
		sbl_pkg::ST_AREA: begin
			if (rxv) begin
				n.chip = (rxb == sbl_pkg::AREA_CHIP); // (R17)
				n.sect = !n.chip;
				sec_addr = {rxb[7:4], {sbl_pkg::SECTOR_BITS{1'b0}}};
				pwd_need = !part_blank &&
					(erase_protect_option_code != sbl_pkg::OPT_OPEN);
				refuse = (n.sect && (r.sec || !sec_addr[15] ||
					erase_protect_option_code == sbl_pkg::OPT_OPEN)) ||
					(pwd_need && !password_ok); // (R18) (R20)
				n.base = n.chip ? 15'h0000 : phys(sec_addr); // (R21)
				// A refused erase answers nothing
				n.st = refuse ? sbl_pkg::ST_CMD : sbl_pkg::ST_EXEC;
				n.start = !refuse;
			end
		end
		sbl_pkg::ST_EXEC: begin
			if (r.stream) begin
				n.fwd_v = rxv;
				n.fwd_d = rxv ? rxb : r.fwd_d;
				n.etx_rdy = tx_idle && !(eng_tx_valid && r.etx_rdy);
				push = eng_tx_valid && r.etx_rdy;
				pbyte = eng_tx_data;
				if (cmd_done && cmd_fail) begin
					qload = 1'b1;
					qv = {3{sbl_pkg::ERR_PWD}};
					qc = sbl_pkg::ERR_REPEAT;
					qnext = sbl_pkg::ST_HALT;
				end else if (cmd_done)
					n.st = sbl_pkg::ST_CMD;
			end else if (cmd_done) begin
				n.st = sbl_pkg::ST_CMD;
				if (!cmd_fail) begin
					qload = 1'b1;
					if (r.chip)
						n.sec = 1'b0; // (R19)
					if (r.cmd == sbl_pkg::CMD_SUM) begin
						qv = {checksum[7:0], checksum[15:8],
							sbl_pkg::CHECK_BYTE}; // (R14)
						qc = 2'h3;
					end else begin
						qv[1:0] = {checksum[7:0], checksum[15:8]};
						qc = 2'h2;
					end
				end
			end
		end
		sbl_pkg::ST_SEND: begin
			if (r.qn != 2'h0) begin
				if (tx_idle) begin
					push = 1'b1;
					pbyte = r.q[0];
					n.q = {8'h00, r.q[2:1]};
					n.qn = r.qn - 2'h1;
				end
			end else if (tx_idle) begin
				n.st = r.nxt;
				n.start = (r.nxt == sbl_pkg::ST_EXEC);
			end
		end
		sbl_pkg::ST_HALT: ;
		default: n.st = sbl_pkg::ST_STANDBY;
		endcase

		if (sio_sel) begin
			n.sio = 1'b1; // (R2)
			qload = 1'b1;
			qv[0] = sbl_pkg::SEL_SIO;
			qc = 2'h1;
			qnext = sbl_pkg::ST_MATCH2;
		end
		if (qload) begin
			n.q = qv;
			n.qn = qc;
			n.nxt = qnext;
			n.st = sbl_pkg::ST_SEND;
		end
		if (push && r.sio) begin
			n.tp = 1'b1;
			n.tbyte = pbyte;
		end else if (push) begin
			n.tb = 1'b1;
			n.line = 1'b0;
			n.ts = {1'b1, pbyte};
			n.tn = 4'h0;
			n.tc = r.per - 16'h0001;
		end
		if (loader_addr_valid && r.cmd == sbl_pkg::CMD_RAMLD)
			n.ram_bad = !in_rng(loader_addr, sbl_pkg::RAM_LO,
				sbl_pkg::RAM_HI); // (R13)

		// Ready only while waiting for a byte from the controller
		n.rdy = (n.st == sbl_pkg::ST_STANDBY) ||
			(n.st == sbl_pkg::ST_MATCH2) || (n.st == sbl_pkg::ST_CMD) ||
			(n.st == sbl_pkg::ST_AREA) ||
			(n.st == sbl_pkg::ST_EXEC && n.stream);
		n.so = r.tp ? r.tbyte[idx] : r.rdy; // (R4)
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
			r.line <= 1'b1;
		end else
			r <= n;
	end

	assign sync_serial_out_pin = r.so;
	assign uart_tx_pin         = r.line;
	assign eng_tx_ready        = r.etx_rdy;
	assign ram_addr_bad        = r.ram_bad;
	assign cmd_start           = r.start;
	assign cmd_code            = r.cmd;
	assign erase_chip          = r.chip;
	assign erase_sector        = r.sect;
	assign erase_base          = r.base;
	assign fwd_valid           = r.fwd_v;
	assign fwd_data            = r.fwd_d;
	assign security_enable     = r.sec;
	assign sio_mode            = r.sio;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	standby_hold_a: assert property ( // (R9)
		r.st == sbl_pkg::ST_STANDBY && !fell && !sio_sel
		|=> r.st == sbl_pkg::ST_STANDBY)
		else $error("standby left without a byte");
	sio_select_a: assert property ( // (R2)
		sio_sel |=> r.sio && r.q[0] == sbl_pkg::SEL_SIO)
		else $error("sync link not selected by 0x30");
	baud_range_a: assert property ( // (R8)
		r.st == sbl_pkg::ST_AB_TAIL |-> r.per >= PW'(sbl_pkg::BIT_MIN_CYC)
		&& r.per <= PW'(BIT_MAX_CYC))
		else $error("measured bit period out of range");
	stop_bit_a: assert property ( // (R6)
		r.tb && r.tn == sbl_pkg::UART_LAST_IDX |-> r.line)
		else $error("uart stop bit not high");
	err_triple_a: assert property ( // (R24)
		r.st == sbl_pkg::ST_CMD && rxv && !r.sec &&
		rxb == 8'h55 |=> r.qn == 2'h3 && r.q[0] == sbl_pkg::ERR_CMD
		&& r.nxt == sbl_pkg::ST_HALT)
		else $error("unknown command not answered thrice");
	halt_sticky_a: assert property ( // (R24)
		r.st == sbl_pkg::ST_HALT |=> r.st == sbl_pkg::ST_HALT)
		else $error("left idle after error");
	sect_refuse_a: assert property ( // (R18)
		r.start && r.sect |-> !$past(r.sec) &&
		$past(erase_protect_option_code) != sbl_pkg::OPT_OPEN)
		else $error("sector erase started while barred");
	pwd_gate_a: assert property ( // (R20)
		r.start && (r.chip || r.sect) |-> $past(password_ok) ||
		$past(part_blank) ||
		$past(erase_protect_option_code) == sbl_pkg::OPT_OPEN)
		else $error("erase started without password");
	chip_clear_a: assert property ( // (R19)
		r.st == sbl_pkg::ST_EXEC && !r.stream && r.chip && cmd_done &&
		!cmd_fail |=> !r.sec)
		else $error("chip erase left security on");
	secure_set_a: assert property ( // (R16)
		r.st == sbl_pkg::ST_CMD && rxv && rxb == sbl_pkg::CMD_SECURE
		|=> r.sec)
		else $error("security not set");
	sector_base_a: assert property ( // (R21)
		r.start && r.sect |-> r.base[11:0] == 12'h000)
		else $error("sector base not aligned");
	busy_low_a: assert property ( // (R4)
		(r.sio && !r.tp && r.st == sbl_pkg::ST_EXEC && !r.stream)[*3]
		|-> !r.so)
		else $error("sync out not busy while processing");

	uart_sel_c: cover property (r.st == sbl_pkg::ST_SEND &&
		r.nxt == sbl_pkg::ST_MATCH2 && !r.sio);
	sio_sel_c: cover property (sio_sel);
	erase_c: cover property (r.start && r.chip);
	halt_c: cover property (r.st == sbl_pkg::ST_HALT);
endmodule // sbl_loader

// [tb/sbl_ctrl_model.sv]
// Programming controller model driving the UART and sync serial links
`timescale 1ns/1ps

// ==========================================================
// Controller model
module sbl_ctrl_model (
	input  wire logic clk,
	input  wire logic txd,
	input  wire logic so,
	output logic      rxd,
	output logic      sclk
);
	localparam int HALF_NS = 80;

	// Shared data wire is pulled up, so released means high
	initial begin
		rxd  = 1'b1;
		sclk = 1'b1;
	end

	// ==========================================================
	// UART frames
	task automatic uart_send(input logic [7:0] b, input int per);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (per) @(posedge clk);
		end
	endtask

	task automatic uart_low(input int len);
		rxd <= 1'b0;
		repeat (len) @(posedge clk);
		rxd <= 1'b1;
		@(posedge clk);
	endtask

	// Mid-bit sampling tolerates small rate error
	task automatic uart_recv(input int per, input int lim,
		output logic [7:0] b, output bit ok);
		b  = 8'h00;
		ok = 1'b0;
		for (int n = 0; n < lim && txd !== 1'b0; n++) @(posedge clk);
		if (txd === 1'b0) begin
			repeat (per + per / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				b[i] = txd;
				repeat (per) @(posedge clk);
			end
			ok = (txd === 1'b1);
		end
	endtask

	// ==========================================================
	// Sync link: clock idles high and runs only inside a byte
	task automatic sio_xfer(input logic [7:0] d, output logic [7:0] q);
		#3;
		for (int i = 0; i < 8; i++) begin
			#HALF_NS sclk = 1'b0;
			q[i] = so;
			rxd  = d[i];
			#HALF_NS sclk = 1'b1;
		end
		#HALF_NS rxd = 1'b1;
	endtask

	task automatic sio_send(input logic [7:0] d, output bit ok);
		logic [7:0] q;
		for (int n = 0; n < 2000 && so !== 1'b1; n++) @(posedge clk);
		ok = (so === 1'b1);
		if (ok) sio_xfer(d, q);
	endtask
endmodule // sbl_ctrl_model

// [tb/sbl_loader_test.sv]
// Self-checking bench for the serial boot command loader
`timescale 1ns/1ps

// ==========================================================
// Bench top
module sbl_loader_test;
	localparam int MAXC = 2000;
	localparam int PER  = 800;

	typedef struct packed {
		logic [7:0] code;
		logic       st;
		logic       eng;
		logic       fw;
	} sbl_row_s;

	logic        clk, rst, sclk, rxd, so, txd;
	logic [7:0]  opt, eng_data, cmd_code, fwd_data, q, fwd_seen;
	logic        part_blank, password_ok, security_strap;
	logic        cmd_done, cmd_fail, eng_valid, eng_ready, la_valid;
	logic        ram_addr_bad, cmd_start, erase_chip, erase_sector;
	logic        fwd_valid, security_enable, sio_mode;
	logic [15:0] checksum, la;
	logic [14:0] erase_base;
	bit          ok, seen, start_hit;
	int          bad_count, num_checks;

	sbl_row_s rows [8] = '{
		'{8'h90, 1'b1, 1'b0, 1'b0},
		'{8'hC0, 1'b1, 1'b1, 1'b0},
		'{8'hC3, 1'b1, 1'b0, 1'b0},
		'{8'h40, 1'b1, 1'b1, 1'b0},
		'{8'h30, 1'b1, 1'b0, 1'b1},
		'{8'h60, 1'b1, 1'b0, 1'b1},
		'{8'hD0, 1'b0, 1'b0, 1'b0},
		'{8'hFA, 1'b0, 1'b0, 1'b0}};

	sbl_loader #(.BIT_MAX_CYC(MAXC)) dut (
		.clk(clk), .rst(rst), .sync_serial_clock_pin(sclk),
		.sync_serial_in_pin(rxd), .sync_serial_out_pin(so),
		.uart_rx_pin(rxd), .uart_tx_pin(txd),
		.erase_protect_option_code(opt), .part_blank(part_blank),
		.password_ok(password_ok), .security_strap(security_strap),
		.cmd_done(cmd_done), .cmd_fail(cmd_fail), .checksum(checksum),
		.eng_tx_valid(eng_valid), .eng_tx_data(eng_data),
		.eng_tx_ready(eng_ready), .loader_addr(la),
		.loader_addr_valid(la_valid), .ram_addr_bad(ram_addr_bad),
		.cmd_start(cmd_start), .cmd_code(cmd_code),
		.erase_chip(erase_chip), .erase_sector(erase_sector),
		.erase_base(erase_base), .fwd_valid(fwd_valid),
		.fwd_data(fwd_data), .security_enable(security_enable),
		.sio_mode(sio_mode));

	sbl_ctrl_model ctrl (.clk(clk), .txd(txd), .so(so), .rxd(rxd),
		.sclk(sclk));

	always #5 clk = ~clk;

	always @(posedge clk) if (fwd_valid === 1'b1) fwd_seen <= fwd_data;

	// The start pulse lasts one cycle and often passes during a serial read
	always @(posedge clk) if (cmd_start === 1'b1) start_hit <= 1'b1;

	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [15:0] seen_v,
		input logic [15:0] exp);
		num_checks++;
		if (seen_v !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen_v);
		end
	endtask

	task automatic wrap_up;
		if (bad_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// A wait that ran out ends the run at once
	task automatic need(input bit good);
		if (!good) begin
			bad_count++;
			wrap_up;
		end
	endtask

	task automatic do_reset(input logic strap);
		rst <= 1'b1;
		security_strap <= strap;
		repeat (6) @(posedge clk);
		#1;
		chk("tx in reset", txd, 1'b1);
		chk("so in reset", so, 1'b0);
		chk("start in reset", cmd_start, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("ready after reset", so, 1'b1);
		chk("strap loaded", security_enable, strap);
		chk("mode after reset", sio_mode, 1'b0);
		@(posedge clk);
	endtask

	// Reply bytes become pending a few cycles after the request
	task automatic sio_rd(output logic [7:0] d);
		repeat (40) @(posedge clk);
		ctrl.sio_xfer(8'hFF, d);
		@(posedge clk);
	endtask

	task automatic sio_cmd(input logic [7:0] c, input logic [7:0] exp);
		ctrl.sio_send(c, ok);
		need(ok);
		sio_rd(q);
		chk("reply", q, exp);
	endtask

	task automatic sio_setup(input logic strap);
		do_reset(strap);
		sio_cmd(sbl_pkg::SEL_SIO, sbl_pkg::SEL_SIO);
		chk("link mode", sio_mode, 1'b1);
		sio_cmd(sbl_pkg::MATCH2_A, sbl_pkg::MATCH2_A);
	endtask

	task automatic wait_start(input int lim);
		seen = 1'b0;
		for (int n = 0; n < lim && !seen; n++) begin
			@(posedge clk);
			#1;
			seen = start_hit;
		end
		start_hit = 1'b0;
		@(posedge clk);
	endtask

	task automatic eng_done(input logic f);
		cmd_done <= 1'b1;
		cmd_fail <= f;
		@(posedge clk);
		cmd_done <= 1'b0;
		cmd_fail <= 1'b0;
	endtask

	task automatic eng_push(input logic [7:0] d);
		eng_valid <= 1'b1;
		eng_data  <= d;
		ok = 1'b0;
		for (int n = 0; n < 500 && !ok; n++) begin
			@(posedge clk);
			ok = (eng_ready === 1'b1);
		end
		eng_valid <= 1'b0;
		need(ok);
	endtask

	task automatic uart_pair(input logic [7:0] b);
		fork
			ctrl.uart_send(b, PER);
			ctrl.uart_recv(PER, 40000, q, ok);
		join
		need(ok);
		chk("uart echo", q, b);
		@(posedge clk);
	endtask

	task automatic erase(input logic [7:0] area, input logic go);
		sio_cmd(sbl_pkg::CMD_ERASE, sbl_pkg::CMD_ERASE);
		ctrl.sio_send(area, ok);
		need(ok);
		@(posedge clk);
		wait_start(300);
		chk("erase started", seen, go);
		if (go) begin
			chk("chip flag", erase_chip, area == 8'h00);
			chk("sector flag", erase_sector, area != 8'h00);
			if (area != 8'h00)
				chk("base", erase_base, {area[7:4], 12'h000} - 16'h8000);
			eng_done(1'b0);
			sio_rd(q);
			chk("sum high", q, 8'h5A);
			sio_rd(q);
			chk("sum low", q, 8'h3C);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		clk = 1'b0;
		{rst, part_blank, password_ok, security_strap, la_valid} = 5'h10;
		{cmd_done, cmd_fail, eng_valid} = 3'h0;
		{opt, eng_data, la, checksum} = {8'h00, 8'h00, 16'h0000, 16'h5A3C};
		@(posedge clk);
		do_reset(1'b0);
		ctrl.uart_low(700);
		ctrl.uart_recv(PER, 12000, q, ok);
		chk("short pulse silent", ok, 1'b0);
		uart_pair(sbl_pkg::SEL_UART);
		uart_pair(sbl_pkg::MATCH2_B);
		sio_setup(1'b0);
		foreach (rows[i]) begin
			sio_cmd(rows[i].code, rows[i].code);
			if (rows[i].st) begin
				wait_start(300);
				chk("start", seen, 1'b1);
				chk("code", cmd_code, rows[i].code);
			end
			if (rows[i].fw) begin
				ctrl.sio_send(8'h11, ok);
				need(ok);
				repeat (40) @(posedge clk);
				chk("forward", fwd_seen, 8'h11);
			end
			if (rows[i].eng) begin
				eng_push(8'hE5);
				sio_rd(q);
				chk("engine byte", q, 8'hE5);
			end
			if (rows[i].code == sbl_pkg::CMD_RAMLD) begin
				for (int k = 0; k < 4; k++) begin
					la <= k[1] ? 16'h083F + 16'(k[0]) : 16'h005F + 16'(k[0]);
					la_valid <= 1'b1;
					@(posedge clk);
					la_valid <= 1'b0;
					repeat (2) @(posedge clk);
					#1;
					chk("ram range", ram_addr_bad,
						la < sbl_pkg::RAM_LO || la > sbl_pkg::RAM_HI);
					@(posedge clk);
				end
			end
			if (rows[i].st) eng_done(1'b0);
			if (rows[i].code == sbl_pkg::CMD_SUM) begin
				for (int k = 0; k < 3; k++) begin
					sio_rd(q);
					chk("sum out", q, k == 0 ? 8'hFF : (k == 1 ? 8'h5A : 8'h3C));
				end
			end
		end
		chk("secured", security_enable, 1'b1);
		erase(8'h9A, 1'b0);
		password_ok <= 1'b1;
		erase(8'h00, 1'b1);
		chk("security cleared", security_enable, 1'b0);
		opt <= 8'hFF;
		erase(8'h9A, 1'b0);
		opt <= 8'h00;
		erase(8'hA0, 1'b1);
		password_ok <= 1'b0;
		erase(8'h00, 1'b0);
		part_blank <= 1'b1;
		erase(8'h00, 1'b1);
		sio_cmd(sbl_pkg::CMD_ID, sbl_pkg::CMD_ID);
		wait_start(300);
		eng_done(1'b1);
		for (int k = 0; k < 3; k++) begin
			sio_rd(q);
			chk("fail code", q, sbl_pkg::ERR_PWD);
		end
		// Secured write, then an unknown code, each in a fresh session
		for (int s = 0; s < 2; s++) begin
			sio_setup(s == 0);
			ctrl.sio_send(s == 0 ? 8'h30 : 8'h55, ok);
			need(ok);
			for (int k = 0; k < 3; k++) begin
				sio_rd(q);
				chk("error code", q, s == 0 ? 8'hA3 : 8'hA1);
			end
		end
		wrap_up;
	end
endmodule // sbl_loader_test
